/* rtl/fdp_pkg.sv */
// Package: register map, field layout, reset values and types of the flash protect / command object slice
package fdp_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte-wide registers, 8-bit address)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INDEX = 8'h01; // Command word index register
  localparam logic [7:0] OFS_STATUS = 8'h06; // Flash status register
  localparam logic [7:0] OFS_PROT = 8'h09; // Data-flash protection
  localparam logic [7:0] OFS_COB_HI = 8'h0a; // Indexed command object, high byte
  localparam logic [7:0] OFS_COB_LO = 8'h0b; // Indexed command object, low byte
  localparam logic [7:0] OFS_RSV_A = 8'h0c; // Factory reserved a
  localparam logic [7:0] OFS_RSV_B = 8'h0d; // Factory reserved b

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PROT_OPEN_BIT = 7; // Protection-open bit
  localparam int PROT_SIZE_MSB = 4; // Protection-size field msb
  localparam int STAT_DONE_BIT = 7; // Command complete flag
  localparam int STAT_ACC_ERR_BIT = 5; // Access error flag
  localparam int STAT_VIOL_BIT = 4; // Protection violation flag

  // ----------------------------------------------------------------
  // Reset values and geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] PROT_SIZE_FULL = 5'h1f; // All size bits set
  localparam logic [2:0] INDEX_RESET = 3'h0; // Index after reset
  localparam int COB_WORDS = 6; // Implemented command object words
  localparam logic [22:0] DFLASH_BASE = 23'h10_0000; // Start of protected region
  localparam int SECTOR_SHIFT = 8; // 256-byte protection granule

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Controller sequencing, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_BUSY = 3'b100
  } fdp_state_t;

  // Command handed to the flash engine at launch
  typedef struct packed {
    logic [7:0] code; // Command code field
    logic [22:0] addr; // Global address
    logic [63:0] data; // Data words 3..0
  } fdp_cmd_t;

  // Result word written back by the engine
  typedef struct packed {
    logic we; // Write enable
    logic [2:0] idx; // Word index
    logic [15:0] word; // Word value
  } fdp_result_t;
endpackage

/* rtl/fdp_top.sv */
// Data-flash protection register and indexed command object array with launch control
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fdp_top
  import fdp_pkg::*;
#(
  parameter logic [7:0] CMD_PROG_D = 8'h01, // D-flash program code, arbitrary value
  parameter logic [7:0] CMD_ERASE_SECT_D = 8'h02, // D-flash sector erase code, arbitrary value
  parameter logic [7:0] CMD_ERASE_BLK_D = 8'h03 // D-flash block erase code, arbitrary value
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] nv_prot_byte,
  input wire logic nv_dbl_fault,
  output logic cmd_launch,
  output fdp_cmd_t cmd_out,
  input wire logic cmd_done,
  input wire fdp_result_t result_in,
  output logic [7:0] prot_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cob_r [0:COB_WORDS-1]; // Command object words
  logic [2:0] index_r; // Selected word
  logic prot_open_r; // Protection-open bit
  logic [4:0] prot_size_r; // Protection-size field
  logic load_pend_r; // Nonvolatile load still due
  logic acc_err_r; // Access error flag
  logic viol_flag_r; // Protection violation flag
  fdp_state_t state_r; // Launch sequencer
  fdp_state_t state_nxt;
  logic [7:0] rdata_r; // Read data, one cycle after strobe
  logic launch_r; // Launch pulse to engine
  fdp_cmd_t cmd_r; // Command captured at launch
  logic [7:0] prot_q_r; // Protection byte mirror

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire cmd_complete = state_r[0]; // Complete flag is the idle state bit
  wire wr_index = wr && (addr == OFS_INDEX);
  wire wr_status = wr && (addr == OFS_STATUS);
  wire wr_prot = wr && (addr == OFS_PROT);
  wire idx_ok = index_r < 3'(COB_WORDS); // Index names an implemented word
  // Object writes need the idle state and an implemented word, so a running command keeps its operands
  wire wr_hi = wr && (addr == OFS_COB_HI) && cmd_complete && idx_ok;
  wire wr_lo = wr && (addr == OFS_COB_LO) && cmd_complete && idx_ok;
  wire [15:0] cur_word = idx_ok ? cob_r[index_r] : 16'h0000;
  // Launch request: write 1 to the complete flag while idle
  wire launch_req = wr_status && wdata[STAT_DONE_BIT] && cmd_complete;
  // A pending error flag blocks the next launch
  wire flags_set = acc_err_r || viol_flag_r;

  // ----------------------------------------------------------------
  // Protection check on the staged command
  // ----------------------------------------------------------------
  wire [7:0] cmd_code = cob_r[0][15:8];
  wire [22:0] cmd_addr = {cob_r[0][6:0], cob_r[1]};
  wire [13:0] region_len = 14'((14'(prot_size_r) + 14'h0001) << SECTOR_SHIFT);
  wire [22:0] region_end = DFLASH_BASE + 23'(region_len);
  // Open bit makes the size field irrelevant
  wire addr_prot = !prot_open_r && (cmd_addr >= DFLASH_BASE) && (cmd_addr < region_end);
  wire any_prot = !prot_open_r; // Smallest region is never empty
  wire alter_cmd = (cmd_code == CMD_PROG_D) || (cmd_code == CMD_ERASE_SECT_D);
  wire viol = (alter_cmd && addr_prot) || ((cmd_code == CMD_ERASE_BLK_D) && any_prot);

  // ----------------------------------------------------------------
  // Protection write filter
  // ----------------------------------------------------------------
  // Whole write accepted only if nothing is weakened
  wire new_open = wdata[PROT_OPEN_BIT];
  wire [4:0] new_size = wdata[PROT_SIZE_MSB:0];
  wire prot_ok = (!new_open || prot_open_r) && (new_size >= prot_size_r);
  // Double fault on load forces full protection
  wire load_open = nv_dbl_fault ? 1'b0 : nv_prot_byte[PROT_OPEN_BIT];
  wire [4:0] load_size = nv_dbl_fault ? PROT_SIZE_FULL : nv_prot_byte[PROT_SIZE_MSB:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] prot_byte = {prot_open_r, 2'b00, prot_size_r};
  // Status byte: complete flag, access error, violation; other bits read zero
  wire [7:0] stat_byte = {cmd_complete, 1'b0, acc_err_r, viol_flag_r, 4'h0};
  wire [7:0] rd_mux =
    (addr == OFS_INDEX) ? {5'h00, index_r} :
    (addr == OFS_STATUS) ? stat_byte :
    (addr == OFS_PROT) ? prot_byte :
    (addr == OFS_COB_HI) ? cur_word[15:8] :
    (addr == OFS_COB_LO) ? cur_word[7:0] :
    8'h00; // reserved and unmapped read zero

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        // Launch refused while an error flag is pending
        if (launch_req && !flags_set)
          state_nxt = ST_CHECK;
      end
      ST_CHECK:
      begin
        // A violation completes at once without touching memory
        state_nxt = viol ? ST_IDLE : ST_BUSY;
      end
      ST_BUSY:
      begin
        if (cmd_done)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer, flags and launch
  // ----------------------------------------------------------------
  // Hardware set wins over software write-1 clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      acc_err_r <= 1'b0;
      viol_flag_r <= 1'b0;
      launch_r <= 1'b0;
      cmd_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      launch_r <= (state_r == ST_CHECK) && !viol;
      if (state_r == ST_CHECK)
        cmd_r <= '{code: cmd_code, addr: cmd_addr,
                   data: {cob_r[5], cob_r[4], cob_r[3], cob_r[2]}};
      if (launch_req && flags_set)
        acc_err_r <= 1'b1;
      else if (wr_status && wdata[STAT_ACC_ERR_BIT])
        acc_err_r <= 1'b0;
      if ((state_r == ST_CHECK) && viol)
        viol_flag_r <= 1'b1;
      else if (wr_status && wdata[STAT_VIOL_BIT])
        viol_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Protection register and nonvolatile load
  // ----------------------------------------------------------------
  // Reset holds full protection until the load lands one edge later
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prot_open_r <= 1'b0;
      prot_size_r <= PROT_SIZE_FULL;
      load_pend_r <= 1'b1;
    end
    else if (load_pend_r)
    begin
      prot_open_r <= load_open;
      prot_size_r <= load_size;
      load_pend_r <= 1'b0;
    end
    else if (wr_prot && prot_ok)
    begin
      prot_open_r <= new_open;
      prot_size_r <= new_size;
    end
  end

  // ----------------------------------------------------------------
  // Index register and command object array
  // ----------------------------------------------------------------
  // Engine results land only while busy, so readers see them after completion
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      index_r <= INDEX_RESET;
      for (int i = 0; i < COB_WORDS; i++)
        cob_r[i] <= 16'h0000;
    end
    else
    begin
      if (wr_index)
        index_r <= wdata[2:0];
      if (wr_hi)
        cob_r[index_r][15:8] <= wdata;
      if (wr_lo)
        cob_r[index_r][7:0] <= wdata;
      if (state_r == ST_BUSY && result_in.we && result_in.idx < 3'(COB_WORDS))
        cob_r[result_in.idx] <= result_in.word;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Read data stands for one cycle and is zero otherwise
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_r <= 8'h00;
      prot_q_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rd ? rd_mux : 8'h00;
      prot_q_r <= prot_byte;
    end
  end

  assign rdata = rdata_r;
  assign cmd_launch = launch_r;
  assign cmd_out = cmd_r;
  assign prot_q = prot_q_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Size may only grow once the reset load has landed
  chk_size_no_shrink: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(load_pend_r) && $past(reset_n) |-> prot_size_r >= $past(prot_size_r))
    else $error("protection size shrank");
  // Software can never raise the open bit again
  chk_open_no_raise: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(load_pend_r) && $past(reset_n) && $past(!prot_open_r) |-> !prot_open_r)
    else $error("protection open bit raised");
  // A refused write leaves the whole byte alone
  chk_bad_write_held: assert property (@(posedge clk) disable iff (!reset_n)
    wr_prot && !prot_ok && !load_pend_r |=> $stable(prot_byte))
    else $error("rejected protection write changed register");
  // Double fault on load leaves data flash fully protected
  chk_dbl_fault_load: assert property (@(posedge clk) disable iff (!reset_n)
    load_pend_r && nv_dbl_fault |=> !prot_open_r && prot_size_r == PROT_SIZE_FULL)
    else $error("double fault did not force full protection");
  // A violation completes at once without a launch
  chk_viol_no_launch: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && viol |=> viol_flag_r && !cmd_launch && cmd_complete)
    else $error("protected command was launched");
  // Launch goes through the check cycle, then pulse or violation
  chk_launch_clears: assert property (@(posedge clk) disable iff (!reset_n)
    launch_req && !flags_set |=> !cmd_complete ##1 (cmd_launch || viol_flag_r))
    else $error("launch sequence broken");
  // Address words frozen while a command runs
  chk_lock_busy: assert property (@(posedge clk) disable iff (!reset_n)
    !cmd_complete && !(state_r == ST_BUSY && result_in.we) |=> $stable(cob_r[0]) && $stable(cob_r[1]))
    else $error("command object changed while locked");
  // Unimplemented indices read zero
  chk_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rd && (addr == OFS_COB_HI || addr == OFS_COB_LO) && index_r >= 3'(COB_WORDS) |=> rdata == 8'h00)
    else $error("unused index read nonzero");
  // Reserved registers read zero
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rd && (addr == OFS_RSV_A || addr == OFS_RSV_B) |=> rdata == 8'h00)
    else $error("reserved register read nonzero");
  // With the open bit set no command is refused for its address
  chk_open_unprot: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && prot_open_r |=> cmd_launch)
    else $error("open bit did not disable protection");

  // Flattened view of the array for whole-array stability checks
  wire [95:0] cob_flat = {cob_r[5], cob_r[4], cob_r[3], cob_r[2], cob_r[1], cob_r[0]};
  // Last protected byte of the region, worked out from base and size field
  wire [22:0] last_prot = DFLASH_BASE + {10'h000, prot_size_r, 8'hff};

  // No software write reaches any word while the flag is clear
  chk_lock_words: assert property (@(posedge clk) disable iff (!reset_n)
    !cmd_complete && !(state_r == ST_BUSY && result_in.we) |=> $stable(cob_flat))
    else $error("command object word written while locked");
  // Writes through an unimplemented index are dropped
  chk_idx_drop: assert property (@(posedge clk) disable iff (!reset_n)
    wr && (addr == OFS_COB_HI || addr == OFS_COB_LO) && !idx_ok && state_r != ST_BUSY |=> $stable(cob_flat))
    else $error("write through unused index landed");
  // The last byte of the region is still protected
  chk_last_byte: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && cmd_code == CMD_PROG_D && !prot_open_r && cmd_addr == last_prot |=> viol_flag_r && !cmd_launch)
    else $error("last protected byte was programmed");
  // The byte just past the region is free
  chk_past_end: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && cmd_code == CMD_PROG_D && cmd_addr == last_prot + 23'h000001 |=> cmd_launch)
    else $error("byte past protected region refused");
  // Block erase refused whenever protection is on
  chk_blk_erase: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && cmd_code == CMD_ERASE_BLK_D && !prot_open_r |=> viol_flag_r && !cmd_launch)
    else $error("block erase ran while protected");
  // A clean load copies the nonvolatile byte
  chk_nv_load: assert property (@(posedge clk) disable iff (!reset_n)
    load_pend_r && !nv_dbl_fault |=> prot_byte == ($past(nv_prot_byte) & 8'h9f))
    else $error("nonvolatile protection byte not loaded");
  // Completion returns the flag on the next edge
  chk_done_ready: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_BUSY && cmd_done |=> cmd_complete)
    else $error("complete flag not returned after done");
  // The engine sees one pulse per command
  chk_launch_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_launch |=> !cmd_launch)
    else $error("launch pulse longer than one cycle");
  // Unused protection bits read zero
  chk_prot_pad: assert property (@(posedge clk) disable iff (!reset_n)
    rd && addr == OFS_PROT |=> rdata[6:5] == 2'b00)
    else $error("unused protection bits read nonzero");
  // Launch with an error flag pending is refused and flagged
  chk_err_launch: assert property (@(posedge clk) disable iff (!reset_n)
    launch_req && flags_set |=> acc_err_r && cmd_complete && !cmd_launch)
    else $error("launch with pending error not refused");

endmodule // fdp_top
`default_nettype wire

/* tb/fdp_top_tb.sv */
// Self-checking bench for the flash protection and command object block
`timescale 1ns/1ps
`default_nettype none
module fdp_top_tb
  import fdp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 100 MHz clock
  logic reset_n = 1'b0; // Synchronous reset, active low
  logic [7:0] addr = 8'h00; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [7:0] rdata; // Read data
  logic [7:0] nv_prot_byte = 8'h85; // Nonvolatile protection byte
  logic nv_dbl_fault = 1'b0; // Fault on nonvolatile read
  logic cmd_launch; // Launch pulse
  fdp_cmd_t cmd_out; // Launched command
  logic cmd_done = 1'b0; // Engine done
  fdp_result_t result_in = '0; // Engine result write
  logic [7:0] prot_q; // Protection mirror
  int mismatches = 0; // Mismatch count
  int cmp_count = 0; // Comparison count
  int cycles = 0; // Timeout counter
  logic [7:0] rv; // Last read value
  logic seen; // Launch observed
  logic [31:0] rows [22]; // {write addr, data, read addr, expected}

  fdp_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .nv_prot_byte(nv_prot_byte), .nv_dbl_fault(nv_dbl_fault), .cmd_launch(cmd_launch), .cmd_out(cmd_out),
    .cmd_done(cmd_done), .result_in(result_in), .prot_q(prot_q));

  // Clock toggles every half period
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  // Compare task for every result kind; unknowns never match
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the next cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    cmp({24'h0, rv}, {24'h0, exp});
  endtask

  // Reset held 12 cycles with a chosen nonvolatile byte
  task automatic do_reset(input logic [7:0] nv, input logic flt);
    reset_n <= 1'b0;
    nv_prot_byte <= nv;
    nv_dbl_fault <= flt;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // Launch write, then watch a few cycles for the pulse and read status
  task automatic launch(input logic exp_seen, input logic [7:0] exp_stat);
    wr_reg(OFS_STATUS, 8'h80);
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1 if (cmd_launch === 1'b1) seen = 1'b1;
    end
    cmp({31'h0, seen}, {31'h0, exp_seen});
    rd_chk(OFS_STATUS, exp_stat);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{
      32'h09830985, 32'h09060906, 32'h09860906, 32'h09050906,
      32'h09080908, 32'h09680908, 32'h0cff0c00, 32'h0dff0d00,
      32'h01070107, 32'h0aff0a00, 32'h0bff0b00, 32'h01060a00,
      32'h01020a00, 32'h0a120a12, 32'h0b340a12, 32'h01000b00,
      32'h0a010a01, 32'h0b100b10, 32'h01010101, 32'h0a090a09,
      32'h0b000b00, 32'h01020b34};
    do_reset(8'h85, 1'b0);
    rd_chk(OFS_PROT, 8'h85);
    cmp({24'h0, prot_q}, 32'h85);
    foreach (rows[i])
    begin
      wr_reg(rows[i][31:24], rows[i][23:16]);
      rd_chk(rows[i][15:8], rows[i][7:0]);
    end
    // Valid program just past the protected end (size 8)
    rd_chk(OFS_STATUS, 8'h80);
    launch(1'b1, 8'h00);
    cmp({24'h0, cmd_out.code}, 32'h01);
    cmp({9'h0, cmd_out.addr}, 32'h100900);
    cmp({16'h0, cmd_out.data[15:0]}, 32'h1234);
    // Object is locked while the command runs
    wr_reg(OFS_COB_HI, 8'hee);
    rd_chk(OFS_COB_HI, 8'h12);
    @(posedge clk);
    result_in <= '{we: 1'b1, idx: 3'h2, word: 16'hbeef};
    @(posedge clk);
    result_in <= '0;
    cmd_done <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
    rd_chk(OFS_STATUS, 8'h80);
    rd_chk(OFS_COB_HI, 8'hbe);
    rd_chk(OFS_COB_LO, 8'hef);
    // Last protected byte is refused
    wr_reg(OFS_INDEX, 8'h01);
    wr_reg(OFS_COB_HI, 8'h08);
    wr_reg(OFS_COB_LO, 8'hff);
    launch(1'b0, 8'h90);
    launch(1'b0, 8'hb0);
    wr_reg(OFS_STATUS, 8'h30);
    rd_chk(OFS_STATUS, 8'h80);
    // Sector erase inside the region, then block erase, both refused
    wr_reg(OFS_INDEX, 8'h00);
    wr_reg(OFS_COB_HI, 8'h02);
    launch(1'b0, 8'h90);
    wr_reg(OFS_STATUS, 8'h10);
    wr_reg(OFS_COB_HI, 8'h03);
    launch(1'b0, 8'h90);
    wr_reg(OFS_STATUS, 8'h10);
    // Faulty load gives full protection
    do_reset(8'h00, 1'b1);
    rd_chk(OFS_PROT, 8'h1f);
    rd_chk(OFS_STATUS, 8'h80);
    // Open bit set: size no longer guards the base address
    do_reset(8'h9f, 1'b0);
    rd_chk(OFS_PROT, 8'h9f);
    cmp({24'h0, prot_q}, 32'h9f);
    wr_reg(OFS_COB_HI, 8'h01);
    wr_reg(OFS_COB_LO, 8'h10);
    wr_reg(OFS_INDEX, 8'h05);
    wr_reg(OFS_COB_LO, 8'h5a);
    launch(1'b1, 8'h00);
    cmp({9'h0, cmd_out.addr}, 32'h100000);
    cmp({16'h0, cmd_out.data[63:48]}, 32'h005a);
    close_out();
  end
endmodule // fdp_top_tb
`default_nettype wire
